// file: src/gpp_pkg.sv
// Package with register map, field positions and sizes of the parallel port block
package gpp_pkg;
  localparam int PORT_CNT    = 4;
  localparam int PORT_W      = 8;
  localparam int PIN_CNT     = 32;
  localparam int PIN_CNT_SML = 28;
  localparam int ADR_W       = 8;
  // Register byte offsets, one word per port per control kind
  localparam logic [7:0] DATA_OFS  = 8'h00;
  localparam logic [7:0] DIR_OFS   = 8'h10;
  localparam logic [7:0] PULL_OFS  = 8'h20;
  localparam logic [7:0] SLEW_OFS  = 8'h30;
  localparam logic [7:0] OUTV_OFS  = 8'h40;
  localparam logic [7:0] INFO_OFS  = 8'h50;
  localparam int          KIND_LSB = 4;
  localparam int          PORT_LSB = 2;
  // Reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST  = 8'h00;
  localparam logic [7:0] PULL_RST = 8'h00;
  localparam logic [7:0] SLEW_RST = 8'h00;
  // Output-only pin: first port, bit two
  localparam int          OUT_ONLY_PORT = 0;
  localparam int          OUT_ONLY_BIT  = 2;
  localparam logic [7:0]  OUT_ONLY_MASK = 8'h04;
  // Pins absent on the smaller variant: upper half of the last port
  localparam logic [31:0] SML_PIN_MASK = 32'h0FFF_FFFF;
  typedef enum logic [1:0] {
    GPP_BUS_IDLE,
    GPP_BUS_ACK
  } gpp_bus_e;
endpackage

// file: src/gpp_sync.sv
// Two-stage synchroniser bank for the pad inputs
module gpp_sync (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] d_i,
  output logic      [31:0] q_o
);
  logic [31:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 32'h0000_0000;
      q_o    <= 32'h0000_0000;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// file: src/gpp_top.sv
// General purpose parallel port block with classic Wishbone register slave
module gpp_top #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Pads, one bit per pin, port a in bits 7:0 up to port d in 31:24
  input  wire logic [31:0] pad_in_i,
  output logic      [31:0] pad_out_o,
  output logic      [31:0] pad_oe_o,
  output logic      [31:0] pad_pullup_o,
  output logic      [31:0] pad_slew_o,
  // Shared on-chip peripherals
  input  wire logic [31:0] periph_own_i,
  input  wire logic [31:0] periph_out_i,
  input  wire logic [31:0] periph_oe_i
);
  localparam logic [31:0] PIN_MASK = SMALL_VARIANT ? gpp_pkg::SML_PIN_MASK : 32'hFFFF_FFFF;
  // Direction bits forced set: bit two of port a is an output unless a peripheral owns it
  localparam logic [31:0] FORCE_OUT = {24'h00_0000, gpp_pkg::OUT_ONLY_MASK};

  logic [31:0] data_r;
  logic [31:0] dir_r;
  logic [31:0] pull_r;
  logic [31:0] slew_r;
  logic [31:0] pin_sync;
  logic [31:0] pin_in;
  logic [31:0] dir_eff;
  logic [31:0] rd_nxt;
  logic        hit;
  logic        req;
  logic        wr_stb;
  logic [2:0]  kind;
  logic [1:0]  port;
  logic [7:0]  wr_byte;
  logic        ack_r;
  logic        err_r;

  gpp_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pad_in_i),
    .q_o   (pin_sync)
  );

  // Output-only pin has no input path; absent pins read zero
  assign pin_in  = pin_sync & PIN_MASK & ~FORCE_OUT;
  assign dir_eff = (dir_r | FORCE_OUT) & PIN_MASK;

  // Bus decode: a single aligned word per port, byte lane 0 only carries data
  assign req     = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
  assign kind    = wb_adr_i[6:4];
  assign port    = wb_adr_i[3:2];
  assign hit     = (wb_adr_i[1:0] == 2'b00) & (kind <= 3'h5) & ~wb_adr_i[7];
  assign wr_stb  = req & hit & wb_we_i & wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];

  // Read mux: data kind returns pin level, not the output latch
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (kind)
      3'h0:    rd_nxt[7:0] = pin_in[port*8 +: 8];
      3'h1:    rd_nxt[7:0] = dir_eff[port*8 +: 8];
      3'h2:    rd_nxt[7:0] = pull_r[port*8 +: 8];
      3'h3:    rd_nxt[7:0] = slew_r[port*8 +: 8];
      3'h4:    rd_nxt[7:0] = data_r[port*8 +: 8];
      3'h5:    rd_nxt = {24'h00_0000, SMALL_VARIANT ? 8'(gpp_pkg::PIN_CNT_SML)
                                                    : 8'(gpp_pkg::PIN_CNT)};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Per-port register storage, reset to inputs with pullups and slew off
  genvar g;
  generate
    for (g = 0; g < gpp_pkg::PORT_CNT; g++) begin : g_port
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          data_r[g*8 +: 8] <= gpp_pkg::DATA_RST;
          dir_r[g*8 +: 8]  <= gpp_pkg::DIR_RST;
          pull_r[g*8 +: 8] <= gpp_pkg::PULL_RST;
          slew_r[g*8 +: 8] <= gpp_pkg::SLEW_RST;
        end else if (wr_stb && port == 2'(g)) begin
          case (kind)
            3'h0:    data_r[g*8 +: 8] <= wr_byte;
            3'h1:    dir_r[g*8 +: 8]  <= wr_byte;
            3'h2:    pull_r[g*8 +: 8] <= wr_byte;
            3'h3:    slew_r[g*8 +: 8] <= wr_byte;
            3'h4:    data_r[g*8 +: 8] <= wr_byte;
            default: ;
          endcase
        end
      end
    end
  endgenerate

  // One-cycle answer; ack drops the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      err_r    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_r    <= req & hit;
      err_r    <= req & ~hit;
      wb_dat_o <= (req & hit & ~wb_we_i) ? rd_nxt : 32'h0000_0000;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;

  // Pad drive: a peripheral that owns a pin overrides the port; release hands back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_out_o    <= 32'h0000_0000;
      pad_oe_o     <= 32'h0000_0000;
      pad_pullup_o <= 32'h0000_0000;
      pad_slew_o   <= 32'h0000_0000;
    end else begin
      pad_out_o    <= ((periph_own_i & periph_out_i) | (~periph_own_i & data_r)) & PIN_MASK;
      pad_oe_o     <= ((periph_own_i & periph_oe_i) | (~periph_own_i & dir_eff)) & PIN_MASK;
      // Pullup only on an undriven pin, so it never fights an output
      pad_pullup_o <= pull_r & ~((periph_own_i & periph_oe_i) | (~periph_own_i & dir_eff))
                      & PIN_MASK;
      pad_slew_o   <= slew_r & PIN_MASK;
    end
  end
endmodule

// file: tb/gpp_board.sv
// Board model: each pad shows the block's drive, else the pullup, else the board level
module gpp_board (
  input  wire logic [31:0] out_i,
  input  wire logic [31:0] oe_i,
  input  wire logic [31:0] pull_i,
  input  wire logic [31:0] ext_i,
  output logic      [31:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pad_o = (oe_i & out_i) | (~oe_i & (pull_i | ext_i));
endmodule

// file: tb/gpp_top_properties.sv
// Checker for bus answers and pad behaviour of the parallel port block
module gpp_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [31:0] pad_out_o,
  input wire logic [31:0] pad_oe_o,
  input wire logic [31:0] pad_pullup_o,
  input wire logic [31:0] periph_own_i,
  input wire logic [31:0] periph_out_i,
  input wire logic [31:0] periph_oe_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o)
    else $error("no answer");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_out_only: assert property (!periph_own_i[2] |=> pad_oe_o[2])
    else $error("output-only pin not driven");
  a_pull_input: assert property ((pad_pullup_o & pad_oe_o) == 32'h0)
    else $error("pullup on driven pin");
  a_periph_oe: assert property (1'b1 |=> ((pad_oe_o ^ $past(periph_oe_i)) & $past(periph_own_i)) == 32'h0)
    else $error("owned pin enable wrong");
  a_periph_out: assert property (1'b1 |=>
    ((pad_out_o ^ $past(periph_out_i)) & $past(periph_own_i & periph_oe_i)) == 32'h0)
    else $error("owned pin value wrong");
  a_reset_vals: assert property ($fell(rst_i) |-> (pad_oe_o | pad_out_o | pad_pullup_o) == 32'h0)
    else $error("pads not at reset state");
  c_err: cover property (wb_err_o);
  c_owned: cover property (periph_own_i != 32'h0 && pad_oe_o[9:8] == 2'h3);
  c_pull: cover property (pad_pullup_o != 32'h0);
endmodule

bind gpp_top gpp_props i_props (.*);

// file: tb/gpp_top_tb.sv
// Self-checking bench for the parallel port block
module gpp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic        wb_ack_o, wb_err_o, er;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, pad_in_i, pad_out_o, pad_oe_o, pad_pullup_o, pad_slew_o, q;
  logic [31:0] periph_own_i = 32'h0, periph_out_i = 32'h0000_0F00, periph_oe_i = 32'h0000_0300;
  int          mismatches = 0, compares = 0, cycles = 0;
  always #12.5 clk_i = ~clk_i;
  gpp_top i_dut (.*);
  gpp_board i_board (.out_i(pad_out_o), .oe_i(pad_oe_o), .pull_i(pad_pullup_o),
                     .ext_i(32'h5A3C_00FF), .pad_o(pad_in_i));
  task wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, 24'h0, d};
    do @(posedge clk_i); while (!wb_ack_o && !wb_err_o);
    {q, er} = {wb_dat_o, wb_err_o};
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Pad outputs are registered one cycle behind the bus answer
  task settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) if (++cycles == 3000) begin
    mismatches++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 1; k < 5; k++)
      for (int p = 0; p < 4; p++) begin
        wb(1'b0, 8'(16 * k + 4 * p), 8'h00);
        chk(q, (k == 1 && p == 0) ? 32'h04 : 32'h00);
      end
    wb(1'b0, gpp_pkg::INFO_OFS, 8'h00); chk(q, 32'h20);
    $display("test 1 done");
    wb(1'b1, 8'h14, 8'hFF); wb(1'b1, 8'h44, 8'hA5); settle;
    chk(pad_oe_o[15:8], 32'hFF);
    chk(pad_out_o[15:8], 32'hA5);
    wb(1'b0, 8'h04, 8'h00); chk(q, 32'hA5);
    wb(1'b0, 8'h08, 8'h00); chk(q, 32'h3C);
    wb(1'b0, 8'h00, 8'h00); chk(q, 32'hFB);
    wb(1'b1, 8'h28, 8'hFF); settle; chk(pad_pullup_o[23:16], 32'hFF);
    wb(1'b1, 8'h18, 8'h0F); settle; chk(pad_pullup_o[23:16], 32'hF0);
    repeat (2) @(posedge clk_i);
    wb(1'b0, 8'h08, 8'h00); chk(q, 32'hF0);
    wb(1'b1, 8'h0C, 8'h33); wb_sel_i <= 4'hE; wb(1'b1, 8'h4C, 8'hFF); wb_sel_i <= 4'hF;
    wb(1'b0, 8'h4C, 8'h00); chk(q, 32'h33);
    wb(1'b1, 8'h3C, 8'h5A); settle; chk(pad_slew_o[31:24], 32'h5A);
    wb(1'b1, 8'h10, 8'h00); wb(1'b0, 8'h10, 8'h00); chk(q, 32'h04);
    $display("test 2 done");
    @(posedge clk_i);
    periph_own_i <= 32'h0000_0F00;
    settle;
    chk(pad_oe_o[15:8], 32'hF3);
    chk(pad_out_o[15:8], 32'hAF);
    @(posedge clk_i);
    periph_own_i <= 32'h0;
    settle;
    chk(pad_out_o[15:8], 32'hA5);
    wb(1'b0, 8'h80, 8'h00); chk(er, 1'b1);
    $display("test 3 done");
    end_of_test;
  end
endmodule
